/* inc/scp_regs.svh */
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// register offsets on the 8-bit register port
`define SCP_OFS_PRESCALE        8'h61
`define SCP_OFS_TRIM            8'h66
`define SCP_OFS_TOSC_CTRL       8'h70

// clock_prescale_control fields
`define SCP_PCE_BIT             7
`define SCP_SEL_MSB             3
`define SCP_SEL_LSB             0
`define SCP_PCE_ARM_VALUE       8'h80

// timer oscillator control fields
`define SCP_TOSC_REQ_BIT        0
`define SCP_TOSC_EXT_BIT        1

// reset values and largest legal select code
`define SCP_SEL_RST_UNPROG      4'h0
`define SCP_SEL_RST_DIV8        4'h3
`define SCP_SEL_MAX_LEGAL       4'h8
`define SCP_TRIM_RST            8'h00
`define SCP_TOSC_RST            2'h0

// timing counts, in undivided clock cycles
`define SCP_UNLOCK_CYCLES       3'h4

`endif

/* inc/scp_pkg.sv */
package scp_pkg;

	// change-unlock window state
	typedef enum logic [0:0]
	{
		SCP_ULK_IDLE  = 1'b0,
		SCP_ULK_ARMED = 1'b1
	} scp_ulk_state_t;

	// divider switch state
	typedef enum logic [0:0]
	{
		SCP_DIV_RUN     = 1'b0,
		SCP_DIV_PENDING = 1'b1
	} scp_div_state_t;

	typedef logic [3:0] scp_sel_t;

endpackage

/* inc/scp_div_if.sv */
`timescale 1ns/100ps

// link between the register side and the ripple divider
interface scp_div_if;
	import scp_pkg::*;

	scp_sel_t new_sel;
	logic     load;
	logic     clk_en;

	modport ctl
	(
		output new_sel,
		output load,
		input  clk_en
	);

	modport div
	(
		input  new_sel,
		input  load,
		output clk_en
	);
endinterface

/* src/scp_divider.sv */
`timescale 1ns/100ps
`include "scp_regs.svh"

// power-of-two divider running on the undivided clock
module scp_divider
	import scp_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control side
	scp_div_if.div    dif
);

	scp_div_state_t state_ff;
	scp_div_state_t nxt_state;
	scp_sel_t       act_sel_ff;
	scp_sel_t       pend_sel_ff;
	scp_sel_t       nxt_pend_sel;
	logic [7:0]     cnt_ff;
	logic           en_ff;
	logic           term;
	logic           switch_now;

	// reserved codes divide as the largest legal factor
	function automatic logic [7:0] sel_mask(input scp_sel_t sel);
		scp_sel_t eff;
		eff = (sel > `SCP_SEL_MAX_LEGAL) ? `SCP_SEL_MAX_LEGAL : sel;
		sel_mask = 8'(9'((9'h001 << eff) - 9'h001));
	endfunction

	// an active edge when the low bits of the counter are all ones
	assign term         = ((cnt_ff & sel_mask(act_sel_ff)) == sel_mask(act_sel_ff));
	// switch only on an old active edge, so no short period appears
	assign switch_now   = term && (state_ff == SCP_DIV_PENDING);
	assign nxt_pend_sel = dif.load ? dif.new_sel : pend_sel_ff;
	assign dif.clk_en   = en_ff;

	// pending state: a later load replaces the one still waiting
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			SCP_DIV_RUN:     if (dif.load) nxt_state = SCP_DIV_PENDING;
			SCP_DIV_PENDING: if (switch_now && !dif.load) nxt_state = SCP_DIV_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= SCP_DIV_RUN;
			pend_sel_ff <= `SCP_SEL_RST_UNPROG;
		end
		else
		begin
			state_ff    <= nxt_state;
			pend_sel_ff <= nxt_pend_sel;
		end
	end

	// ripple counter; restarts so the new period is whole
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff     <= 8'h00;
			act_sel_ff <= `SCP_SEL_RST_UNPROG;
		end
		else if (switch_now)
		begin
			cnt_ff     <= 8'h00;
			act_sel_ff <= pend_sel_ff;
		end
		else
			cnt_ff <= 8'(cnt_ff + 8'h01);
	end

	// one-cycle enable per divided period
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			en_ff <= 1'b0;
		else
			en_ff <= term;
	end

endmodule

/* src/scp_top.sv */
`timescale 1ns/100ps
`include "scp_regs.svh"

module scp_top
	import scp_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// fuse, factory value and clock source status
	input  wire logic       div8_fuse_programmed,
	input  wire logic [7:0] factory_trim,
	input  wire logic       sys_src_is_rc,
	// divided clock enables
	output logic            clk_io_en,
	output logic            clk_adc_en,
	output logic            clk_cpu_en,
	output logic            clk_flash_en,
	// rc oscillator trim
	output logic      [7:0] rc_oscillator_trim,
	// timer oscillator pin control
	output logic            timer_osc_pins_en,
	output logic            timer_osc_external_input_select
);

	scp_div_if dif ();

	scp_ulk_state_t ulk_ff;
	scp_ulk_state_t nxt_ulk;
	logic [2:0]     ulk_cnt_ff;
	logic [2:0]     nxt_ulk_cnt;
	scp_sel_t       division_select_ff;
	scp_sel_t       nxt_division_select;
	logic [7:0]     trim_ff;
	logic [7:0]     nxt_trim;
	logic [1:0]     tosc_ctrl_ff;
	logic [1:0]     nxt_tosc_ctrl;
	logic           tosc_en_ff;
	logic           tosc_ext_ff;
	logic           init_ff;
	logic [7:0]     rdata_ff;
	logic [7:0]     nxt_rdata;

	// address decode
	wire hit_pre  = (reg_addr == `SCP_OFS_PRESCALE);
	wire hit_trim = (reg_addr == `SCP_OFS_TRIM);
	wire hit_tosc = (reg_addr == `SCP_OFS_TOSC_CTRL);
	wire wr_pre   = reg_wr && hit_pre;
	wire wr_trim  = reg_wr && hit_trim;
	wire wr_tosc  = reg_wr && hit_tosc;

	// write qualification on the prescale register
	wire arm_write = wr_pre && (reg_wdata == `SCP_PCE_ARM_VALUE);
	wire sel_write = wr_pre && !reg_wdata[`SCP_PCE_BIT]
		&& (ulk_ff == SCP_ULK_ARMED);
	wire ulk_last  = (ulk_ff == SCP_ULK_ARMED) && (ulk_cnt_ff == 3'h1);

	// strap and factory values, caught at the first edge after release
	wire      [7:0] trim_load = factory_trim;
	wire scp_sel_t  sel_strap = div8_fuse_programmed ? `SCP_SEL_RST_DIV8
		: `SCP_SEL_RST_UNPROG;

	// change-unlock window: fixed length, rearm ignored
	always_comb
	begin
		nxt_ulk     = ulk_ff;
		nxt_ulk_cnt = ulk_cnt_ff;
		unique case (ulk_ff)
			SCP_ULK_IDLE:
			begin
				if (arm_write)
				begin
					nxt_ulk     = SCP_ULK_ARMED;
					nxt_ulk_cnt = `SCP_UNLOCK_CYCLES;
				end
			end
			SCP_ULK_ARMED:
			begin
				// rearm leaves count untouched
				nxt_ulk_cnt = 3'(ulk_cnt_ff - 3'h1);
				if (sel_write || ulk_last)
				begin
					nxt_ulk     = SCP_ULK_IDLE;
					nxt_ulk_cnt = 3'h0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ulk_ff     <= SCP_ULK_IDLE;
			ulk_cnt_ff <= 3'h0;
		end
		else
		begin
			ulk_ff     <= nxt_ulk;
			ulk_cnt_ff <= nxt_ulk_cnt;
		end
	end

	// division select: strap at start, then any code software writes
	assign nxt_division_select = init_ff ? sel_strap
		: sel_write ? reg_wdata[`SCP_SEL_MSB:`SCP_SEL_LSB]
		: division_select_ff;

	// trim register: factory value at start, then software
	assign nxt_trim = init_ff ? trim_load
		: wr_trim ? reg_wdata
		: trim_ff;

	assign nxt_tosc_ctrl = wr_tosc ? reg_wdata[`SCP_TOSC_EXT_BIT:`SCP_TOSC_REQ_BIT]
		: tosc_ctrl_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			init_ff            <= 1'b1;
			division_select_ff <= `SCP_SEL_RST_UNPROG;
			trim_ff            <= `SCP_TRIM_RST;
			tosc_ctrl_ff       <= `SCP_TOSC_RST;
		end
		else
		begin
			init_ff            <= 1'b0;
			division_select_ff <= nxt_division_select;
			trim_ff            <= nxt_trim;
			tosc_ctrl_ff       <= nxt_tosc_ctrl;
		end
	end

	// hand a new select to the divider on strap load or a write
	assign dif.new_sel = nxt_division_select;
	assign dif.load    = init_ff || sel_write;

	scp_divider u_div
	(
		.clk   (clk),
		.rst_n (rst_n),
		.dif   (dif)
	);

	// one enable drives all four synchronous clock groups
	assign clk_io_en    = dif.clk_en;
	assign clk_adc_en   = dif.clk_en;
	assign clk_cpu_en   = dif.clk_en;
	assign clk_flash_en = dif.clk_en;

	// trim goes straight out; bit 7 range, bits 6..0 fine
	assign rc_oscillator_trim = trim_ff;

	// timer oscillator grant, registered
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tosc_en_ff  <= 1'b0;
			tosc_ext_ff <= 1'b0;
		end
		else
		begin
			tosc_en_ff  <= tosc_ctrl_ff[`SCP_TOSC_REQ_BIT] && sys_src_is_rc;
			tosc_ext_ff <= tosc_ctrl_ff[`SCP_TOSC_REQ_BIT] && sys_src_is_rc
				&& tosc_ctrl_ff[`SCP_TOSC_EXT_BIT];
		end
	end

	assign timer_osc_pins_en               = tosc_en_ff;
	assign timer_osc_external_input_select = tosc_ext_ff;

	// read mux; bits 6..4 of prescale read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (reg_rd)
		begin
			if (hit_pre)
				nxt_rdata = {(ulk_ff == SCP_ULK_ARMED), 3'h0, division_select_ff};
			else if (hit_trim)
				nxt_rdata = trim_ff;
			else if (hit_tosc)
				nxt_rdata = {6'h00, tosc_ctrl_ff};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;

endmodule

/* verification/scp_top_chk.sv */
`timescale 1ns/100ps
// port checker for the prescaler block
module scp_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// straps and status
	input wire logic       div8_fuse_programmed,
	input wire logic [7:0] factory_trim,
	input wire logic       sys_src_is_rc,
	// outputs under watch
	input wire logic       clk_io_en,
	input wire logic       clk_adc_en,
	input wire logic       clk_cpu_en,
	input wire logic       clk_flash_en,
	input wire logic [7:0] rc_oscillator_trim,
	input wire logic       timer_osc_pins_en,
	input wire logic       timer_osc_external_input_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [8:0] gap_ff;

	// cycles since the last cpu enable pulse
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) gap_ff <= 9'h000;
		else gap_ff <= clk_cpu_en ? 9'h000 : gap_ff + 9'h001;

	// port relations
	en_tied_a: assert property (clk_io_en == clk_cpu_en && clk_adc_en == clk_cpu_en
		&& clk_flash_en == clk_cpu_en) else $error("enables differ");
	pins_rc_a: assert property (timer_osc_pins_en |-> $past(sys_src_is_rc))
		else $error("pins without rc");
	ext_pin_a: assert property (timer_osc_external_input_select |-> timer_osc_pins_en)
		else $error("ext without pins");
	trim_wr_a: assert property (reg_wr && reg_addr == 8'h66
		|=> rc_oscillator_trim == $past(reg_wdata)) else $error("trim not written");
	trim_hold_a: assert property ($past(rst_n) && !(reg_wr && reg_addr == 8'h66)
		|=> $stable(rc_oscillator_trim)) else $error("trim moved");
	trim_rd_a: assert property (reg_rd && reg_addr == 8'h66
		|=> reg_rdata == $past(rc_oscillator_trim)) else $error("trim read");
	sel_zero_a: assert property (reg_rd && reg_addr == 8'h61 |=> reg_rdata[6:4] == 3'h0)
		else $error("bits 6 to 4 set");
	gap_max_a: assert property (gap_ff < 9'h100) else $error("enable gap");

	// main scenarios reached
	cover property (reg_wr && reg_addr == 8'h61 && reg_wdata == 8'h80);
	cover property (timer_osc_external_input_select);
	cover property (clk_cpu_en ##1 !clk_cpu_en);
endmodule

bind scp_top scp_chk i_chk
(
	.clk                             (clk),
	.rst_n                           (rst_n),
	.reg_addr                        (reg_addr),
	.reg_wdata                       (reg_wdata),
	.reg_wr                          (reg_wr),
	.reg_rd                          (reg_rd),
	.reg_rdata                       (reg_rdata),
	.div8_fuse_programmed            (div8_fuse_programmed),
	.factory_trim                    (factory_trim),
	.sys_src_is_rc                   (sys_src_is_rc),
	.clk_io_en                       (clk_io_en),
	.clk_adc_en                      (clk_adc_en),
	.clk_cpu_en                      (clk_cpu_en),
	.clk_flash_en                    (clk_flash_en),
	.rc_oscillator_trim              (rc_oscillator_trim),
	.timer_osc_pins_en               (timer_osc_pins_en),
	.timer_osc_external_input_select (timer_osc_external_input_select)
);

/* verification/scp_top_tb.sv */
`timescale 1ns/100ps
// directed bench for prescaler, trim and timer pins
module scp_top_tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       div8_fuse_programmed = 1'b1;
	logic       sys_src_is_rc = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] factory_trim = 8'hA5;
	logic [7:0] reg_rdata, rc_oscillator_trim;
	logic       clk_io_en, clk_adc_en, clk_cpu_en, clk_flash_en;
	logic       timer_osc_pins_en, timer_osc_external_input_select;
	int         num_errors = 0;
	int         samples_checked = 0;
	int         cyc = 0;

	scp_top i_dut
	(
		.clk                             (clk),
		.rst_n                           (rst_n),
		.reg_addr                        (reg_addr),
		.reg_wdata                       (reg_wdata),
		.reg_wr                          (reg_wr),
		.reg_rd                          (reg_rd),
		.reg_rdata                       (reg_rdata),
		.div8_fuse_programmed            (div8_fuse_programmed),
		.factory_trim                    (factory_trim),
		.sys_src_is_rc                   (sys_src_is_rc),
		.clk_io_en                       (clk_io_en),
		.clk_adc_en                      (clk_adc_en),
		.clk_cpu_en                      (clk_cpu_en),
		.clk_flash_en                    (clk_flash_en),
		.rc_oscillator_trim              (rc_oscillator_trim),
		.timer_osc_pins_en               (timer_osc_pins_en),
		.timer_osc_external_input_select (timer_osc_external_input_select)
	);

	// 100 MHz clock
	always #5 clk = ~clk;
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	// compare one byte
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// one write cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// one read cycle, data judged in the cycle after
	task automatic rc8(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// settled enable period for code k
	task automatic gap(input int k);
		int n;
		for (int p = 0; p < 3; p++)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				#1 n++;
			end
			while (clk_cpu_en !== 1'b1 && n < 600);
		end
		chk(8'(n - 1), 8'((1 << (k > 8 ? 8 : k)) - 1));
	endtask
	// unlock then select
	task automatic setsel(input logic [7:0] d);
		wr(8'h61, 8'h80);
		wr(8'h61, d);
	endtask
	// reset with a given fuse
	task automatic t_reset(input logic f);
		@(posedge clk);
		div8_fuse_programmed <= f;
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rc8(8'h61, f ? 8'h03 : 8'h00);
		rc8(8'h66, 8'hA5);
		gap(f ? 3 : 0);
	endtask
	// every legal select code, plus reserved code 9
	task automatic t_codes();
		for (int k = 0; k < 10; k++)
		begin
			setsel(8'(k));
			rc8(8'h61, 8'(k));
			gap(k);
		end
	endtask
	// unlock window edge cases
	task automatic t_window();
		wr(8'h61, 8'hF0);
		wr(8'h61, 8'h02);
		rc8(8'h61, 8'h09);
		wr(8'h61, 8'h80);
		rc8(8'h61, 8'h89);
		@(posedge clk);
		wr(8'h61, 8'h02);
		rc8(8'h61, 8'h09);
		wr(8'h61, 8'h80);
		wr(8'h61, 8'h80);
		rc8(8'h61, 8'h89);
		wr(8'h61, 8'h02);
		rc8(8'h61, 8'h09);
		setsel(8'h75);
		rc8(8'h61, 8'h05);
	endtask
	// trim range boundaries
	task automatic t_trim();
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h66, 8'h7F + 8'(i));
			rc8(8'h66, 8'h7F + 8'(i));
			chk(rc_oscillator_trim, 8'h7F + 8'(i));
		end
	endtask
	// timer pins follow request and rc source
	task automatic t_tosc();
		@(posedge clk);
		sys_src_is_rc <= 1'b1;
		wr(8'h70, 8'h03);
		repeat (2) @(posedge clk);
		#1 chk({6'h00, timer_osc_pins_en, timer_osc_external_input_select}, 8'h03);
		wr(8'h70, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({6'h00, timer_osc_pins_en, timer_osc_external_input_select}, 8'h02);
		@(posedge clk);
		sys_src_is_rc <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, timer_osc_pins_en, timer_osc_external_input_select}, 8'h00);
		rc8(8'h62, 8'h00);
	endtask
	// report and stop
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// main sequence
	initial
	begin
		t_reset(1'b1);
		t_codes();
		t_window();
		t_trim();
		t_tosc();
		t_reset(1'b0);
		give_verdict();
	end
endmodule
